// ---- ppc_map.vh ----
// Register indices, kinds, decoder hit codes and reset values of the port block
`ifndef PPC_MAP_VH
`define PPC_MAP_VH
// Register indices; byte address is four times the index
`define PPC_IDX_DATA_PORT0 8'h18
`define PPC_IDX_DATA_PORT1 8'h19
`define PPC_IDX_DATA_PORT3 8'h1b
`define PPC_IDX_DATA_PORT5 8'h1d
`define PPC_IDX_DATA_PORT6 8'h1e
`define PPC_IDX_DATA_PORT7 8'h1f
`define PPC_IDX_DATA_PORT16 8'hb0
`define PPC_IDX_DATA_PORT17 8'hb1
`define PPC_IDX_DATA_PORT8 8'hb8
`define PPC_IDX_DATA_PORT11 8'hbb
`define PPC_IDX_DATA_PORT12 8'hbc
`define PPC_IDX_DATA_PORT15 8'hbf
`define PPC_IDX_DIR_PORT0 8'h20
`define PPC_IDX_DIR_PORT1 8'h21
`define PPC_IDX_DIR_PORT3 8'h23
`define PPC_IDX_DIR_PORT5 8'h25
`define PPC_IDX_DIR_PORT6 8'h26
`define PPC_IDX_DIR_PORT7 8'h27
`define PPC_IDX_DIR_PORT16 8'hb2
`define PPC_IDX_DIR_PORT17 8'hb3
`define PPC_IDX_DIR_PORT8 8'hc0
`define PPC_IDX_DIR_PORT11 8'hc3
`define PPC_IDX_DIR_PORT15 8'hc5
`define PPC_IDX_ALT_PORT0 8'h28
`define PPC_IDX_ALT_PORT1 8'h29
`define PPC_IDX_ALT_PORT3 8'h2b
`define PPC_IDX_ALT_PORT5 8'h2d
`define PPC_IDX_ALT_PORT6 8'h2e
`define PPC_IDX_ALT_PORT7 8'h2f
`define PPC_IDX_ALT_PORT16 8'hb4
`define PPC_IDX_ALT_PORT17 8'hb5
`define PPC_IDX_ALT_PORT15 8'hc7
`define PPC_IDX_ALT_PORT8 8'hc8
`define PPC_IDX_ALT_PORT11 8'hcb
// Register kinds
`define PPC_KIND_DATA 2'h0
`define PPC_KIND_DIR 2'h1
`define PPC_KIND_ALT 2'h2
`define PPC_KIND_INPUT 2'h3
// Decoder hit bit over kind
`define PPC_HIT_D 3'h4
`define PPC_HIT_M 3'h5
`define PPC_HIT_A 3'h6
`define PPC_HIT_I 3'h7
// Reset values
`define PPC_RST_ZERO 8'h00
`define PPC_RST_EXT_FULL 8'hff
`define PPC_RST_EXT_PORT3 8'h03
`endif

// ---- ppc_port_pins.v ----
// Port pin configuration: direction, pull-up and alternate routing
`timescale 1ns/1ps
`include "ppc_map.vh"
module ppc_port_pins (
    // Clock and reset
    input wire clk_sys,
    input wire srst,
    // Further reset sources, same clock
    input wire software_break_instruction,
    input wire watchdog_overflow,
    input wire opcode_trap,
    // Avalon-MM slave
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Strap pin
    input wire external_fetch_select,
    // Pads, eleven ports of 8 bits in slot order
    input wire [87:0] pad_in,
    output wire [87:0] pad_out,
    output wire [87:0] pad_oe,
    output wire [87:0] pad_pullup_en,
    // Input-only port, bits 4 to 7
    input wire [3:0] analog_input_port,
    output wire [3:0] adc_analog_in,
    // External memory unit
    input wire [7:0] muxed_lowbyte_out,
    input wire muxed_lowbyte_oe,
    output wire [7:0] muxed_lowbyte_bus,
    input wire [7:0] upper_address_byte,
    input wire address_latch_strobe,
    input wire program_fetch_strobe,
    input wire data_read_strobe,
    input wire data_write_strobe,
    // Timer 0 and interrupts
    input wire timer0_output,
    output wire timer0_event_input,
    output wire [1:0] external_irq_line,
    // Pulse outputs
    input wire [1:0] pulse_channel_output,
    // Serial 1
    output wire serial1_receive_line,
    input wire serial1_transmit_line,
    input wire serial1_rxclk_out,
    input wire serial1_rxclk_oe,
    output wire serial1_receive_clock,
    input wire serial1_txclk_out,
    input wire serial1_txclk_oe,
    output wire serial1_transmit_clock,
    // Serial 6
    output wire serial6_receive_line,
    input wire serial6_transmit_line,
    input wire serial6_rxclk_out,
    input wire serial6_rxclk_oe,
    output wire serial6_receive_clock,
    input wire serial6_txclk_out,
    input wire serial6_txclk_oe,
    output wire serial6_transmit_clock,
    // Clock out
    input wire main_clock_pulse,
    // Three-phase unit, u high first
    input wire [5:0] phase_pwm_output,
    output wire abnormality_detect_input,
    // Capture and compare
    output wire [1:0] capture_input,
    input wire [1:0] compare_output,
    input wire [1:0] compare_oe,
    output wire [1:0] capture_compare_pin
);

    // ==========================================
    // Slots
    localparam NSLOT = 11;
    localparam NBIT = 88;
    localparam [3:0] SLOT_PORT0 = 4'h0;
    localparam [3:0] SLOT_PORT1 = 4'h1;
    localparam [3:0] SLOT_PORT3 = 4'h2;
    localparam [3:0] SLOT_PORT5 = 4'h3;
    localparam [3:0] SLOT_PORT6 = 4'h4;
    localparam [3:0] SLOT_PORT7 = 4'h5;
    localparam [3:0] SLOT_PORT8 = 4'h6;
    localparam [3:0] SLOT_PORT11 = 4'h7;
    localparam [3:0] SLOT_PORT15 = 4'h8;
    localparam [3:0] SLOT_PORT16 = 4'h9;
    localparam [3:0] SLOT_PORT17 = 4'ha;

    // ==========================================
    // Functions
    // Reset setting of direction and alternate bits
    function [7:0] ppc_cfg_rst;
        input [3:0] slot;
        input ea_low;
        begin
            case (slot)
                SLOT_PORT0, SLOT_PORT1: begin
                    ppc_cfg_rst = ea_low ? `PPC_RST_EXT_FULL
                                         : `PPC_RST_ZERO;
                end
                SLOT_PORT3: begin
                    // Bits 2-3 stay zero either way
                    ppc_cfg_rst = ea_low ? `PPC_RST_EXT_PORT3
                                         : `PPC_RST_ZERO;
                end
                default: begin
                    ppc_cfg_rst = `PPC_RST_ZERO;
                end
            endcase
        end
    endfunction

    // Index to {hit, kind, slot}
    function [6:0] ppc_decode;
        input [7:0] idx;
        begin
            case (idx)
                `PPC_IDX_DATA_PORT0: ppc_decode = {`PPC_HIT_D, SLOT_PORT0};
                `PPC_IDX_DATA_PORT1: ppc_decode = {`PPC_HIT_D, SLOT_PORT1};
                `PPC_IDX_DATA_PORT3: ppc_decode = {`PPC_HIT_D, SLOT_PORT3};
                `PPC_IDX_DATA_PORT5: ppc_decode = {`PPC_HIT_D, SLOT_PORT5};
                `PPC_IDX_DATA_PORT6: ppc_decode = {`PPC_HIT_D, SLOT_PORT6};
                `PPC_IDX_DATA_PORT7: ppc_decode = {`PPC_HIT_D, SLOT_PORT7};
                `PPC_IDX_DATA_PORT8: ppc_decode = {`PPC_HIT_D, SLOT_PORT8};
                `PPC_IDX_DATA_PORT11: ppc_decode = {`PPC_HIT_D, SLOT_PORT11};
                `PPC_IDX_DATA_PORT15: ppc_decode = {`PPC_HIT_D, SLOT_PORT15};
                `PPC_IDX_DATA_PORT16: ppc_decode = {`PPC_HIT_D, SLOT_PORT16};
                `PPC_IDX_DATA_PORT17: ppc_decode = {`PPC_HIT_D, SLOT_PORT17};
                `PPC_IDX_DATA_PORT12: ppc_decode = {`PPC_HIT_I, 4'h0};
                `PPC_IDX_DIR_PORT0: ppc_decode = {`PPC_HIT_M, SLOT_PORT0};
                `PPC_IDX_DIR_PORT1: ppc_decode = {`PPC_HIT_M, SLOT_PORT1};
                `PPC_IDX_DIR_PORT3: ppc_decode = {`PPC_HIT_M, SLOT_PORT3};
                `PPC_IDX_DIR_PORT5: ppc_decode = {`PPC_HIT_M, SLOT_PORT5};
                `PPC_IDX_DIR_PORT6: ppc_decode = {`PPC_HIT_M, SLOT_PORT6};
                `PPC_IDX_DIR_PORT7: ppc_decode = {`PPC_HIT_M, SLOT_PORT7};
                `PPC_IDX_DIR_PORT8: ppc_decode = {`PPC_HIT_M, SLOT_PORT8};
                `PPC_IDX_DIR_PORT11: ppc_decode = {`PPC_HIT_M, SLOT_PORT11};
                `PPC_IDX_DIR_PORT15: ppc_decode = {`PPC_HIT_M, SLOT_PORT15};
                `PPC_IDX_DIR_PORT16: ppc_decode = {`PPC_HIT_M, SLOT_PORT16};
                `PPC_IDX_DIR_PORT17: ppc_decode = {`PPC_HIT_M, SLOT_PORT17};
                `PPC_IDX_ALT_PORT0: ppc_decode = {`PPC_HIT_A, SLOT_PORT0};
                `PPC_IDX_ALT_PORT1: ppc_decode = {`PPC_HIT_A, SLOT_PORT1};
                `PPC_IDX_ALT_PORT3: ppc_decode = {`PPC_HIT_A, SLOT_PORT3};
                `PPC_IDX_ALT_PORT5: ppc_decode = {`PPC_HIT_A, SLOT_PORT5};
                `PPC_IDX_ALT_PORT6: ppc_decode = {`PPC_HIT_A, SLOT_PORT6};
                `PPC_IDX_ALT_PORT7: ppc_decode = {`PPC_HIT_A, SLOT_PORT7};
                `PPC_IDX_ALT_PORT8: ppc_decode = {`PPC_HIT_A, SLOT_PORT8};
                `PPC_IDX_ALT_PORT11: ppc_decode = {`PPC_HIT_A, SLOT_PORT11};
                `PPC_IDX_ALT_PORT15: ppc_decode = {`PPC_HIT_A, SLOT_PORT15};
                `PPC_IDX_ALT_PORT16: ppc_decode = {`PPC_HIT_A, SLOT_PORT16};
                `PPC_IDX_ALT_PORT17: ppc_decode = {`PPC_HIT_A, SLOT_PORT17};
                default: ppc_decode = 7'h00;
            endcase
        end
    endfunction

    // ==========================================
    // Reset and strap
    wire sys_rst = srst | software_break_instruction |
                   watchdog_overflow | opcode_trap;
    // Strap chain has no reset so it runs during reset
    reg ea_s1_q;
    reg ea_s2_q;
    reg ea_s3_q;
    reg ea_q;
    always @(posedge clk_sys) begin
        ea_s1_q <= external_fetch_select;
        ea_s2_q <= ea_s1_q;
        ea_s3_q <= ea_s2_q;
        if (ea_s2_q == ea_s3_q) begin
            ea_q <= ea_s3_q;
        end
    end
    wire ea_low = ~ea_q;

    // ==========================================
    // Pin synchronisers
    localparam SW = NBIT + 4;
    reg [SW-1:0] s1_q;
    reg [SW-1:0] s2_q;
    reg [SW-1:0] s3_q;
    reg [SW-1:0] pin_q;
    always @(posedge clk_sys) begin
        if (srst) begin
            s1_q <= {SW{1'b0}};
            s2_q <= {SW{1'b0}};
            s3_q <= {SW{1'b0}};
            pin_q <= {SW{1'b0}};
        end else begin
            s1_q <= {analog_input_port, pad_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Change taken only once stages two and three agree
            pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
        end
    end
    wire [NBIT-1:0] pin_lvl = pin_q[NBIT-1:0];
    wire [3:0] in_only_lvl = pin_q[SW-1:NBIT];
    // Analog path, not sampled
    assign adc_analog_in = analog_input_port;

    // ==========================================
    // Bus slave, one wait state on every access
    reg ack_q;
    reg [7:0] rdata_q;
    wire req = avs_read | avs_write;
    wire [6:0] dec = ppc_decode(avs_address[9:2]);
    wire dec_hit = dec[6];
    wire [1:0] dec_kind = dec[5:4];
    wire [3:0] dec_slot = dec[3:0];
    wire wr_go = avs_write & ack_q & avs_byteenable[0] & dec_hit;
    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata = {24'h000000, rdata_q};

    // ==========================================
    // Per-slot registers
    wire [NBIT-1:0] latch_all;
    wire [NBIT-1:0] dir_all;
    wire [NBIT-1:0] alt_all;
    genvar s;
    generate
        for (s = 0; s < NSLOT; s = s + 1) begin : g_slot
            localparam [3:0] SLOT = s;
            reg [7:0] latch_q;
            reg [7:0] dir_q;
            reg [7:0] alt_q;
            wire here = wr_go & (dec_slot == SLOT);
            always @(posedge clk_sys) begin
                if (sys_rst) begin
                    latch_q <= `PPC_RST_ZERO;
                    dir_q <= ppc_cfg_rst(SLOT, ea_low);
                    alt_q <= ppc_cfg_rst(SLOT, ea_low);
                end else if (here) begin
                    if (dec_kind == `PPC_KIND_DATA) begin
                        latch_q <= avs_writedata[7:0];
                    end
                    if (dec_kind == `PPC_KIND_DIR) begin
                        dir_q <= avs_writedata[7:0];
                    end
                    if (dec_kind == `PPC_KIND_ALT) begin
                        alt_q <= avs_writedata[7:0];
                    end
                end
            end
            assign latch_all[s*8 +: 8] = latch_q;
            assign dir_all[s*8 +: 8] = dir_q;
            assign alt_all[s*8 +: 8] = alt_q;
        end
    endgenerate

    // ==========================================
    // Read path
    // Inputs show the pin, outputs the latch
    wire [NBIT-1:0] view_all = (dir_all & latch_all) |
                               (~dir_all & pin_lvl);
    wire [6:0] sel = {dec_slot, 3'h0};
    reg [7:0] rd_val;
    always @* begin
        rd_val = 8'h00;
        if (dec_hit) begin
            case (dec_kind)
                `PPC_KIND_DATA: rd_val = view_all[sel +: 8];
                `PPC_KIND_DIR: rd_val = dir_all[sel +: 8];
                `PPC_KIND_ALT: rd_val = alt_all[sel +: 8];
                // Bits 0-3 absent, read zero
                default: rd_val = {in_only_lvl, 4'h0};
            endcase
        end
    end
    always @(posedge clk_sys) begin
        if (srst) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read & ~ack_q) begin
                rdata_q <= rd_val;
            end
        end
    end

    // ==========================================
    // Alternate sources per pin
    wire [NBIT-1:0] alt_out;
    wire [NBIT-1:0] alt_oe;
    // Port 0, bus turns round under the memory unit
    assign alt_out[7:0] = muxed_lowbyte_out;
    assign alt_oe[7:0] = {8{muxed_lowbyte_oe}};
    // Port 1
    assign alt_out[15:8] = upper_address_byte;
    assign alt_oe[15:8] = 8'hff;
    // Port 3
    assign alt_out[23:16] = {4'h0, data_write_strobe, data_read_strobe,
                             program_fetch_strobe,
                             address_latch_strobe};
    assign alt_oe[23:16] = 8'h0f;
    // Port 5
    assign alt_out[31:24] = {1'b0, timer0_output, 6'h00};
    assign alt_oe[31:24] = 8'h40;
    // Port 6, inputs only
    assign alt_out[39:32] = 8'h00;
    assign alt_oe[39:32] = 8'h00;
    // Port 7
    assign alt_out[47:40] = {pulse_channel_output, 6'h00};
    assign alt_oe[47:40] = 8'hc0;
    // Port 8
    assign alt_out[55:48] = {4'h0, serial1_txclk_out, serial1_rxclk_out,
                             serial1_transmit_line, 1'b0};
    assign alt_oe[55:48] = {4'h0, serial1_txclk_oe, serial1_rxclk_oe,
                            2'h2};
    // Port 11
    assign alt_out[63:56] = {5'h00, main_clock_pulse, 2'h0};
    assign alt_oe[63:56] = 8'h04;
    // Port 15
    assign alt_out[71:64] = {4'h0, serial6_txclk_out, serial6_rxclk_out,
                             serial6_transmit_line, 1'b0};
    assign alt_oe[71:64] = {4'h0, serial6_txclk_oe, serial6_rxclk_oe,
                            2'h2};
    // Port 16
    assign alt_out[79:72] = {2'h0, phase_pwm_output};
    assign alt_oe[79:72] = 8'h3f;
    // Port 17
    assign alt_out[87:80] = {4'h0, compare_output, 2'h0};
    assign alt_oe[87:80] = {4'h0, compare_oe, 2'h0};

    // ==========================================
    // Peripheral inputs, always from the synchronised pin
    assign muxed_lowbyte_bus = pin_lvl[7:0];
    assign timer0_event_input = pin_lvl[31];
    assign external_irq_line = pin_lvl[33:32];
    assign serial1_receive_line = pin_lvl[48];
    assign serial1_receive_clock = pin_lvl[50];
    assign serial1_transmit_clock = pin_lvl[51];
    assign serial6_receive_line = pin_lvl[64];
    assign serial6_receive_clock = pin_lvl[66];
    assign serial6_transmit_clock = pin_lvl[67];
    assign abnormality_detect_input = pin_lvl[78];
    assign capture_input = pin_lvl[81:80];
    assign capture_compare_pin = pin_lvl[83:82];

    // ==========================================
    // Pad drive
    // Alternate bit picks pull-up on inputs, source on outputs
    wire [NBIT-1:0] oe_d = dir_all & (~alt_all | alt_oe);
    wire [NBIT-1:0] out_d = (alt_all & alt_out) |
                            (~alt_all & latch_all);
    wire [NBIT-1:0] pull_d = ~dir_all & alt_all;
    reg [NBIT-1:0] pad_out_q;
    reg [NBIT-1:0] pad_oe_q;
    reg [NBIT-1:0] pad_pull_q;
    // Registered pads cost one cycle on every strobe
    always @(posedge clk_sys) begin
        if (srst) begin
            pad_out_q <= {NBIT{1'b0}};
            pad_oe_q <= {NBIT{1'b0}};
            pad_pull_q <= {NBIT{1'b0}};
        end else begin
            pad_out_q <= out_d;
            pad_oe_q <= oe_d;
            pad_pull_q <= pull_d;
        end
    end
    assign pad_out = pad_out_q;
    assign pad_oe = pad_oe_q;
    assign pad_pullup_en = pad_pull_q;

endmodule // ppc_port_pins

// ---- ppc_port_pins_sva.sv ----
// Concurrent checks on the ports of the port pin block
`timescale 1ns/1ps
// ========
// Port pin checker
module ppc_port_pins_sva (
    // Clock and reset sources
    input wire clk_sys,
    input wire srst,
    input wire software_break_instruction,
    input wire watchdog_overflow,
    input wire opcode_trap,
    // Bus
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Pins and units
    input wire external_fetch_select,
    input wire [87:0] pad_in,
    input wire [87:0] pad_out,
    input wire [87:0] pad_oe,
    input wire [87:0] pad_pullup_en,
    input wire [3:0] analog_input_port,
    input wire [3:0] adc_analog_in,
    input wire address_latch_strobe,
    input wire program_fetch_strobe,
    input wire serial1_receive_line,
    input wire abnormality_detect_input,
    input wire [1:0] capture_input
);
    wire req = avs_read | avs_write;
    wire xrst = software_break_instruction | watchdog_overflow | opcode_trap;
    wire [3:0] sync_pins = {pad_in[78], pad_in[48], pad_in[81:80]};
    wire [3:0] sync_outs = {abnormality_detect_input, serial1_receive_line,
        capture_input};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ========
    // Assertions
    AST_ONE_WAIT: assert property (req && !$past(req)
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("request not answered after one wait state");
    AST_IDLE_READY: assert property (!req |-> !avs_waitrequest)
        else $error("wait raised with no request");
    AST_READ_CLEAN: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[31:8] == 24'h0 && (avs_address[9:2] != 8'hff
        || avs_readdata[7:0] == 8'h00))
        else $error("read data not clean");
    AST_PULL_NOT_DRIVEN: assert property ((pad_pullup_en & pad_oe) == 88'h0)
        else $error("pull-up on a driven pin");
    AST_RESET_PADS: assert property ($fell(srst) |-> pad_oe == 88'h0
        && pad_pullup_en == 88'h0 && pad_out == 88'h0)
        else $error("pads active during reset");
    AST_STRAP_LOW: assert property ($fell(srst) && !external_fetch_select
        |-> ##1 pad_oe[17:16] == 2'h3 && pad_oe[23:18] == 6'h0
        && pad_out[17:16] == $past({program_fetch_strobe,
        address_latch_strobe}))
        else $error("bus pins not in bus role after reset");
    AST_STRAP_HIGH: assert property ($fell(srst) && external_fetch_select
        |-> ##1 pad_oe[23:0] == 24'h0 && pad_pullup_en[23:0] == 24'h0)
        else $error("bus pins not plain inputs after reset");
    AST_EXTRA_RESET: assert property (xrst |-> ##2 pad_oe[87:18] == 70'h0
        && pad_out[87:18] == 70'h0)
        else $error("extra reset source left a pin active");
    AST_ADC_ROUTE: assert property (adc_analog_in == analog_input_port)
        else $error("converter input not routed");
    // Six stable samples leave margin over the four-edge pipeline
    AST_PIN_SYNC: assert property ($stable(sync_pins) [*6]
        |-> sync_outs == sync_pins)
        else $error("unit input does not follow pin");
    // ========
    // Covers
    CV_WRITE: cover property (avs_write && !avs_waitrequest);
    CV_PULL: cover property (|pad_pullup_en);
    CV_STRAP_LOW: cover property ($fell(srst) && !external_fetch_select);
endmodule // ppc_port_pins_sva

bind ppc_port_pins ppc_port_pins_sva ppc_port_pins_sva_i (
    .clk_sys(clk_sys), .srst(srst), .opcode_trap(opcode_trap),
    .software_break_instruction(software_break_instruction),
    .watchdog_overflow(watchdog_overflow), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_fetch_select(external_fetch_select), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
    .analog_input_port(analog_input_port), .adc_analog_in(adc_analog_in),
    .address_latch_strobe(address_latch_strobe),
    .program_fetch_strobe(program_fetch_strobe),
    .serial1_receive_line(serial1_receive_line),
    .abnormality_detect_input(abnormality_detect_input),
    .capture_input(capture_input));

// ---- ppc_pin_model.sv ----
// Board-side model of the pins: resolves each pad from all its drivers
`timescale 1ns/1ps
// ========
// Pin resolution
module ppc_pin_model (
    // Clock
    input wire clk_sys,
    // Block side
    input wire [87:0] pad_out,
    input wire [87:0] pad_oe,
    input wire [87:0] pad_pullup_en,
    // Board side
    input wire [87:0] ext_val,
    input wire [87:0] ext_en,
    output wire [87:0] pad_in
);
    logic [87:0] float_q = 88'h0;
    // A floating, unpulled pin wanders so a stale level never passes
    always @(posedge clk_sys) begin
        float_q <= ~float_q;
    end
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en & (pad_pullup_en | float_q));
endmodule // ppc_pin_model

// ---- ppc_port_pins_tb_top.sv ----
// Self-checking bench for the port pin block
`timescale 1ns/1ps
// ========
// Bench top
module ppc_port_pins_tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [2:0] xrst_q = 3'h0;
    logic [9:0] avs_address = 10'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0;
    logic fetch_sel_q = 1'b1;
    logic [87:0] ext_val = 88'h0;
    logic [87:0] ext_en = {88{1'b1}};
    logic [3:0] analog_q = 4'h6;
    logic [44:0] unit_q = 45'h0;
    logic [44:0] pat = 45'h0b5a3c696e1;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [87:0] pad_in, pad_out, pad_oe, pad_pullup_en;
    wire [7:0] muxed_lowbyte_bus;
    wire [1:0] external_irq_line;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] rd;
    logic [7:0] rst_idx [0:7] = '{8'h20, 8'h28, 8'h21, 8'h29, 8'h23, 8'h2b,
        8'h18, 8'h25};
    logic [7:0] rst_low [0:7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h03,
        8'h00, 8'h00};
    logic [7:0] alt_idx [0:11] = '{8'h25, 8'h2d, 8'h27, 8'h2f, 8'hc0, 8'hc8,
        8'hc3, 8'hcb, 8'hb2, 8'hb4, 8'hb3, 8'hb5};
    // ========
    // Design and pins
    ppc_port_pins ppc_port_pins_i (
        .clk_sys(clk_sys), .srst(srst), .opcode_trap(xrst_q[2]),
        .software_break_instruction(xrst_q[0]), .watchdog_overflow(xrst_q[1]),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
        .external_fetch_select(fetch_sel_q), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
        .analog_input_port(analog_q), .adc_analog_in(),
        .muxed_lowbyte_out(unit_q[7:0]), .muxed_lowbyte_oe(unit_q[8]),
        .muxed_lowbyte_bus(muxed_lowbyte_bus),
        .upper_address_byte(unit_q[16:9]),
        .address_latch_strobe(unit_q[17]), .program_fetch_strobe(unit_q[18]),
        .data_read_strobe(unit_q[19]), .data_write_strobe(unit_q[20]),
        .timer0_output(unit_q[21]), .timer0_event_input(),
        .external_irq_line(external_irq_line),
        .pulse_channel_output(unit_q[23:22]), .serial1_receive_line(),
        .serial1_transmit_line(unit_q[24]), .serial1_rxclk_out(unit_q[25]),
        .serial1_rxclk_oe(unit_q[26]), .serial1_receive_clock(),
        .serial1_txclk_out(unit_q[27]), .serial1_txclk_oe(unit_q[28]),
        .serial1_transmit_clock(), .serial6_receive_line(),
        .serial6_transmit_line(unit_q[29]), .serial6_rxclk_out(unit_q[30]),
        .serial6_rxclk_oe(unit_q[31]), .serial6_receive_clock(),
        .serial6_txclk_out(unit_q[32]), .serial6_txclk_oe(unit_q[33]),
        .serial6_transmit_clock(), .main_clock_pulse(unit_q[34]),
        .phase_pwm_output(unit_q[40:35]), .abnormality_detect_input(),
        .capture_input(), .compare_output(unit_q[42:41]),
        .compare_oe(unit_q[44:43]), .capture_compare_pin());
    ppc_pin_model ppc_pin_model_i (.clk_sys(clk_sys), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en), .ext_val(ext_val),
        .ext_en(ext_en), .pad_in(pad_in));
    // ========
    // Tasks
    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test;
        end
    end
    task stop_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task check(input logic [87:0] got, input logic [87:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Request held until wait is low at a rising edge
    task automatic bus(input logic w, input logic [7:0] i, d);
        @(posedge clk_sys);
        avs_address <= {i, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        if (!w) rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task wr(input logic [7:0] i, d);
        bus(1'b1, i, d);
    endtask
    task rdx(input logic [7:0] i);
        bus(1'b0, i, 8'h00);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task do_reset(input logic sel);
        @(posedge clk_sys);
        fetch_sel_q <= sel;
        srst <= 1'b1;
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
    endtask
    // ========
    // Tests
    initial begin
        do_reset(1'b1);
        for (int i = 0; i < 8; i++) begin
            rdx(rst_idx[i]);
            check(rd, 8'h00);
        end
        $display("test strap high done");
        @(posedge clk_sys);
        unit_q <= pat | 45'h100;
        do_reset(1'b0);
        for (int i = 0; i < 8; i++) begin
            rdx(rst_idx[i]);
            check(rd, rst_low[i]);
        end
        tick(6);
        check(pad_out[17:0], {unit_q[18:9],
            unit_q[7:0]});
        check(pad_oe[7:0], 8'hff);
        check(muxed_lowbyte_bus, unit_q[7:0]);
        wr(8'h23, 8'h0f);
        wr(8'h2b, 8'h0f);
        tick(2);
        check({pad_oe[19:16], pad_out[19:18]}, {4'hf, unit_q[20:19]});
        $display("test strap low done");
        do_reset(1'b1);
        for (int i = 0; i < 12; i++) wr(alt_idx[i], 8'hff);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys);
            unit_q <= p ? ~pat : pat;
            tick(2);
            check({pad_out[83:82], pad_out[77:72], pad_out[58], pad_out[51:49],
                pad_out[47:46], pad_out[30]}, {unit_q[42:34], unit_q[27],
                unit_q[25:21]});
            check({pad_oe[83:82], pad_oe[77:72], pad_oe[58], pad_oe[51:46],
                pad_oe[30]}, {unit_q[44:43], 7'h7f, unit_q[28], unit_q[26],
                5'h17});
        end
        $display("test alternates done");
        wr(8'h2e, 8'hff);
        @(posedge clk_sys);
        ext_en[39:32] <= 8'h00;
        tick(6);
        check({pad_pullup_en[39:32], pad_oe[39:32]}, 16'hff00);
        rdx(8'h1e);
        check(rd, 8'hff);
        @(posedge clk_sys);
        ext_en[39:32] <= 8'hff;
        ext_val[39:32] <= 8'h3c;
        wr(8'h1e, 8'h96);
        tick(6);
        check(external_irq_line, 2'h0);
        rdx(8'h1e);
        check(rd, 8'h3c);
        wr(8'h2e, 8'h00);
        wr(8'h26, 8'h0f);
        tick(6);
        check({pad_oe[39:32], pad_out[35:32]}, 12'h0f6);
        rdx(8'h1e);
        check(rd, 8'h36);
        $display("test data path done");
        for (int i = 0; i < 3; i++) begin
            wr(8'h25, 8'hff);
            wr(8'h1d, 8'ha5);
            @(posedge clk_sys);
            xrst_q[i] <= 1'b1;
            @(posedge clk_sys);
            xrst_q[i] <= 1'b0;
            rdx(8'h25);
            check(rd, 8'h00);
            wr(8'h25, 8'hff);
            rdx(8'h1d);
            check(rd, 8'h00);
        end
        $display("test extra resets done");
        rdx(8'hff);
        check(rd, 8'h00);
        @(posedge clk_sys);
        avs_byteenable <= 4'h0;
        wr(8'h27, 8'hff);
        @(posedge clk_sys);
        avs_byteenable <= 4'hf;
        rdx(8'h27);
        check(rd, 8'h00);
        @(posedge clk_sys);
        analog_q <= 4'h9;
        wr(8'hbc, 8'hff);
        tick(6);
        rdx(8'hbc);
        check(rd[7:4], analog_q);
        $display("test refusals done");
        stop_test;
    end
endmodule // ppc_port_pins_tb_top
